//--- prescale_divider.sv
`timescale 1ns/1ps
module prescale_divider #(
   parameter int PW = 3
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Tick link to the timer core
   tick_if.div tl
);
   localparam int DW = (2 ** PW) - 1;
   logic [DW-1:0] div_r;
   logic [DW-1:0] divNxt;
   logic [DW-1:0] divMask;

   // Divide by two to the prescale power
   assign divMask = ~({DW{1'b1}} << tl.prescale);
   assign tl.tick = tl.enable && ((div_r & divMask) == divMask);
   assign divNxt = tl.enable ? div_r + {{(DW-1){1'b0}}, 1'b1} : '0;

   // Free divider, held clear while the timer is off
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         div_r <= '0;
      end else begin
         div_r <= divNxt;
      end
   end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin nErrors++; \
   $display("unexpected at %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
   logic mclk, sysRst, awvalid, wvalid, bready, arvalid, rready, level, route;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdv;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid, timerOut, pinOut, pinOe, irq;
   logic pinIn, eventIn;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int nErrors = 0;
   int nChecks = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Design and input source
   timer_compare_gated_capture #(.PRES_W(3)) u_dut (.mclk(mclk), .sys_rst(sysRst),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .pinIn(pinIn), .eventIn(eventIn),
      .timerOut(timerOut), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
   timer_input_model u_src (.mclk(mclk), .sysRst(sysRst), .level(level), .route(route),
      .pinIn(pinIn), .eventIn(eventIn));

   ////////////////////////////////////////////////////////////////////////////////
   // Bus master tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = timer_pkg::RESP_OKAY);
      int t;
      logic awDone, wDone;
      t = 0;
      awDone = 1'b0;
      wDone = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(awDone && wDone) && t < 100) begin
         @(posedge mclk);
         t++;
         if (!awDone && awready) begin
            awDone = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wDone && wready) begin
            wDone = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge mclk);
         t++;
      end while (bvalid !== 1'b1 && t < 100);
      bready <= 1'b0;
      if (t >= 100) nErrors++;
      `CHK(bresp, er)
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er = timer_pkg::RESP_OKAY);
      int t;
      t = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         t++;
      end while (arready !== 1'b1 && t < 100);
      arvalid <= 1'b0;
      do begin
         @(posedge mclk);
         t++;
      end while (rvalid !== 1'b1 && t < 100);
      rdv = rdata;
      rready <= 1'b0;
      if (t >= 100) nErrors++;
      `CHK(rresp, er)
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      `CHK(rdv, exp)
   endtask

   task automatic waitIrq(input int lim);
      int t;
      t = 0;
      while (irq !== 1'b1 && t < lim) begin
         @(posedge mclk);
         t++;
      end
      `CHK(irq, 1'b1)
   endtask

   task automatic finishTest;
      $display("checks %0d errors %0d", nChecks, nErrors);
      if (nErrors == 0 && nChecks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      nErrors++;
      finishTest;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      sysRst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, level, route} = '0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      repeat (16) @(posedge mclk);
      sysRst <= 1'b0;
      // Reset values and idle outputs
      rdChk(timer_pkg::OFF_COUNT, 32'h0);
      rdChk(timer_pkg::OFF_RELOAD, 32'hffff);
      rdChk(timer_pkg::OFF_CAPTURE, 32'h0);
      rdChk(timer_pkg::OFF_CTRL0, 32'h0);
      rdChk(timer_pkg::OFF_CTRL1, 32'h0);
      rdChk(timer_pkg::OFF_STATUS, 32'h0);
      rdChk(timer_pkg::OFF_MASK, 32'h0);
      `CHK({timerOut, pinOut, pinOe, irq}, 4'h0)
      // Compare: match keeps counting, output toggles, wrap to zero
      wr(timer_pkg::OFF_MASK, 32'h3);
      wr(timer_pkg::OFF_CTRL0, 32'h01);
      wr(timer_pkg::OFF_COUNT, 32'hfff0);
      wr(timer_pkg::OFF_RELOAD, 32'hfff8);
      wr(timer_pkg::OFF_CTRL1, 32'h85);
      waitIrq(100);
      rd(timer_pkg::OFF_COUNT);
      `CHK(rdv[15:4], 12'hfff)
      rdChk(timer_pkg::OFF_STATUS, 32'h1);
      `CHK({timerOut, pinOut, pinOe}, 3'h7)
      wr(timer_pkg::OFF_STATUS, 32'h3);
      `CHK(irq, 1'b0)
      repeat (40) @(posedge mclk);
      wr(timer_pkg::OFF_CTRL1, 32'h05);
      rd(timer_pkg::OFF_COUNT);
      `CHK(rdv[15:8], 8'h00)
      // Prescale by 8: one count per eight clocks
      wr(timer_pkg::OFF_COUNT, 32'h0);
      wr(timer_pkg::OFF_CTRL1, 32'h9d);
      repeat (80) @(posedge mclk);
      wr(timer_pkg::OFF_CTRL1, 32'h1d);
      rd(timer_pkg::OFF_COUNT);
      `CHK(rdv >= 32'h9 && rdv <= 32'hc, 1'b1)
      // Gated mode under every interrupt select code
      for (int i = 0; i < 4; i++) begin
         wr(timer_pkg::OFF_CTRL1, 32'h06);
         wr(timer_pkg::OFF_STATUS, 32'h3);
         wr(timer_pkg::OFF_CTRL0, 32'h01 | (i << 4));
         wr(timer_pkg::OFF_COUNT, 32'h0ffc);
         wr(timer_pkg::OFF_RELOAD, 32'h1000);
         wr(timer_pkg::OFF_CTRL1, 32'h86);
         repeat (10) @(posedge mclk);
         rdChk(timer_pkg::OFF_COUNT, 32'h0ffc);
         level <= 1'b1;
         repeat (12) @(posedge mclk);
         level <= 1'b0;
         repeat (4) @(posedge mclk);
         rdChk(timer_pkg::OFF_STATUS, {30'h0, (i != 3), (i != 2)});
         rd(timer_pkg::OFF_COUNT);
         `CHK(rdv[15:4] == 12'h0 && rdv[3:0] != 4'h0, 1'b1)
         if (i == 0) begin
            `CHK(timerOut, 1'b1)
            rd(timer_pkg::OFF_CTRL0);
            `CHK(rdv[3], 1'b1)
         end
      end
      // Capture/Compare on falling edges of the event line
      wr(timer_pkg::OFF_CTRL1, 32'h47);
      wr(timer_pkg::OFF_STATUS, 32'h3);
      wr(timer_pkg::OFF_CTRL0, 32'h02);
      wr(timer_pkg::OFF_COUNT, 32'h0);
      wr(timer_pkg::OFF_RELOAD, 32'h0100);
      wr(timer_pkg::OFF_CAPTURE, 32'h0);
      route <= 1'b1;
      level <= 1'b1;
      wr(timer_pkg::OFF_CTRL1, 32'hc7);
      repeat (20) @(posedge mclk);
      rdChk(timer_pkg::OFF_COUNT, 32'h0);
      level <= 1'b0;
      repeat (6) @(posedge mclk);
      rdChk(timer_pkg::OFF_STATUS, 32'h0);
      level <= 1'b1;
      repeat (30) @(posedge mclk);
      level <= 1'b0;
      repeat (4) @(posedge mclk);
      rdChk(timer_pkg::OFF_STATUS, 32'h2);
      rd(timer_pkg::OFF_COUNT);
      `CHK(rdv[15:5], 11'h0)
      rd(timer_pkg::OFF_CAPTURE);
      `CHK(rdv[15:6] == 10'h0 && rdv[15:0] != 16'h0, 1'b1)
      rd(timer_pkg::OFF_CTRL0);
      `CHK(rdv[3], 1'b1)
      wr(timer_pkg::OFF_STATUS, 32'h3);
      waitIrq(400);
      rdChk(timer_pkg::OFF_STATUS, 32'h1);
      rd(timer_pkg::OFF_CTRL0);
      `CHK(rdv[3], 1'b0)
      // Mask gates the interrupt line, status clears by writing one
      wr(timer_pkg::OFF_MASK, 32'h0);
      `CHK(irq, 1'b0)
      wr(timer_pkg::OFF_MASK, 32'h1);
      `CHK(irq, 1'b1)
      wr(timer_pkg::OFF_STATUS, 32'h1);
      `CHK(irq, 1'b0)
      // Mode bit 3 in control zero turns the compare code into an unused, frozen mode
      wr(timer_pkg::OFF_CTRL1, 32'h05);
      wr(timer_pkg::OFF_CTRL0, 32'h80);
      wr(timer_pkg::OFF_COUNT, 32'h0);
      wr(timer_pkg::OFF_CTRL1, 32'h85);
      repeat (10) @(posedge mclk);
      rdChk(timer_pkg::OFF_COUNT, 32'h0);
      // Unmapped address answers with an error
      wr(8'h1c, 32'h5a5a, timer_pkg::RESP_SLVERR);
      rd(8'h1c, timer_pkg::RESP_SLVERR);
      `CHK(rdv, 32'h0)
      finishTest;
   end
endmodule

//--- tick_if.sv
`timescale 1ns/1ps
interface tick_if #(parameter int PW = 3);
   logic enable;
   logic [PW-1:0] prescale;
   logic tick;
   modport ctl (output enable, output prescale, input tick);
   modport div (input enable, input prescale, output tick);
endinterface

//--- timer_compare_gated_capture.sv
`timescale 1ns/1ps
// Operation
// - Compare: match interrupts, count keeps going
// - Compare: output inverts on every match
// - Compare: all-ones count wraps to zero
// - Compare: count from timer clock only
// - Gated: count only while input active
// - Gated: deassert and reload interrupt; flag input
// - Gated: reload restarts at one, output inverts
// - Gated: loaded start count only first pass
// - Interrupt select: both, input only, reload only
// - Capture/Compare: idle until first qualifying edge
// - Capture/Compare: first edge raises no interrupt
// - Later edges capture, interrupt, flag, restart
// - Compare hit: interrupt, clear flag, restart
// - Output always to events; pin when enabled
// - Input from pin or event routing
// - Mode MSB lives in control register zero
module timer_compare_gated_capture #(
   parameter int PRES_W = 3
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // AXI4-Lite write address and data
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Timer input sources
   input wire logic pinIn,
   input wire logic eventIn,
   // Timer output, interrupt
   output logic timerOut,
   output logic pinOut,
   output logic pinOe,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic awHeld_r, wHeld_r, bvalid_r, rvalid_r;
   logic [7:0] awAddr_r, ctrl0_r, ctrl1_r;
   logic [31:0] wData_r, rdata_r;
   logic [3:0] wStrb_r;
   logic [1:0] bresp_r, rresp_r, stat_r, statNxt, mask_r;
   logic [15:0] cnt_r, cntNxt, reload_r, cap_r, capNxt;
   logic out_r, outNxt, flag_r, flagNxt, actPrev_r, evReload, evInput;
   timer_pkg::cc_state_t cc_r, ccNxt;
   tick_if #(.PW(PRES_W)) tl ();

   ////////////////////////////////////////////////////////////////////////////////
   // Field decode
   logic enable, polarity, inSel, inAct, qualEdge, gateFall, hit, tick;
   logic [3:0] mode;
   logic [1:0] isel;
   assign enable = ctrl1_r[timer_pkg::C1_EN];
   assign polarity = ctrl1_r[timer_pkg::C1_POL];
   assign mode = {ctrl0_r[timer_pkg::C0_MODE_MSB], ctrl1_r[timer_pkg::C1_MODE_LO +: 3]};
   assign isel = ctrl0_r[timer_pkg::C0_ISEL_LO +: 2];
   assign inSel = ctrl0_r[timer_pkg::C0_IN_SRC] ? eventIn : pinIn;
   assign inAct = inSel ^ polarity;
   assign qualEdge = inAct && !actPrev_r;
   assign gateFall = actPrev_r && !inAct;
   assign hit = (cnt_r == reload_r);
   assign tick = tl.tick;
   // Prescaler link
   assign tl.enable = enable;
   assign tl.prescale = ctrl1_r[timer_pkg::C1_PRES_LO +: PRES_W];

   prescale_divider #(.PW(PRES_W)) divider (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tl(tl)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // Bus write decode
   logic doWrite, wrCount, wrReload, wrCapture, wrCtrl0, wrCtrl1, wrStatus, wrMask, wrHit;
   logic [15:0] wrHalf;
   logic [1:0] statClr;
   assign awready = !awHeld_r && !bvalid_r;
   assign wready = !wHeld_r && !bvalid_r;
   assign doWrite = awHeld_r && wHeld_r;
   assign wrCount = doWrite && (awAddr_r == timer_pkg::OFF_COUNT);
   assign wrReload = doWrite && (awAddr_r == timer_pkg::OFF_RELOAD);
   assign wrCapture = doWrite && (awAddr_r == timer_pkg::OFF_CAPTURE);
   assign wrCtrl0 = doWrite && (awAddr_r == timer_pkg::OFF_CTRL0) && wStrb_r[0];
   assign wrCtrl1 = doWrite && (awAddr_r == timer_pkg::OFF_CTRL1) && wStrb_r[0];
   assign wrStatus = doWrite && (awAddr_r == timer_pkg::OFF_STATUS) && wStrb_r[0];
   assign wrMask = doWrite && (awAddr_r == timer_pkg::OFF_MASK) && wStrb_r[0];
   assign wrHit = (awAddr_r == timer_pkg::OFF_COUNT) || (awAddr_r == timer_pkg::OFF_RELOAD)
      || (awAddr_r == timer_pkg::OFF_CAPTURE) || (awAddr_r == timer_pkg::OFF_CTRL0)
      || (awAddr_r == timer_pkg::OFF_CTRL1) || (awAddr_r == timer_pkg::OFF_STATUS)
      || (awAddr_r == timer_pkg::OFF_MASK);

   // Byte lanes merged onto a 16-bit register
   function automatic logic [15:0] lanes16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      lanes16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   assign wrHalf = lanes16(cnt_r, wData_r, wStrb_r);
   assign statClr = wrStatus ? wData_r[1:0] : 2'h0;
   // Address and data may arrive in either order
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= awaddr;
         end else if (doWrite) begin
            awHeld_r <= 1'b0;
         end
         if (wvalid && wready) begin
            wHeld_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end else if (doWrite) begin
            wHeld_r <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         bvalid_r <= 1'b0;
         bresp_r <= timer_pkg::RESP_OKAY;
      end else if (doWrite) begin
         bvalid_r <= 1'b1;
         bresp_r <= wrHit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus read
   logic [31:0] rdMux;
   logic rdHit;
   logic [7:0] ctrl0View;
   assign ctrl0View = {ctrl0_r[7:4], flag_r, ctrl0_r[2:0]};
   assign rdHit = (araddr == timer_pkg::OFF_COUNT) || (araddr == timer_pkg::OFF_RELOAD)
      || (araddr == timer_pkg::OFF_CAPTURE) || (araddr == timer_pkg::OFF_CTRL0)
      || (araddr == timer_pkg::OFF_CTRL1) || (araddr == timer_pkg::OFF_STATUS)
      || (araddr == timer_pkg::OFF_MASK);
   assign rdMux =
      (araddr == timer_pkg::OFF_COUNT) ? {16'h0000, cnt_r} :
      (araddr == timer_pkg::OFF_RELOAD) ? {16'h0000, reload_r} :
      (araddr == timer_pkg::OFF_CAPTURE) ? {16'h0000, cap_r} :
      (araddr == timer_pkg::OFF_CTRL0) ? {24'h000000, ctrl0View} :
      (araddr == timer_pkg::OFF_CTRL1) ? {24'h000000, ctrl1_r} :
      (araddr == timer_pkg::OFF_STATUS) ? {30'h00000000, stat_r} :
      (araddr == timer_pkg::OFF_MASK) ? {30'h00000000, mask_r} : 32'h0000_0000;
   assign arready = !rvalid_r;

   // Read data captured on the address handshake
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= timer_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= rdMux;
         rresp_r <= rdHit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   ////////////////////////////////////////////////////////////////////////////////
   // Counting engine
   always_comb begin
      cntNxt = cnt_r;
      capNxt = cap_r;
      outNxt = out_r;
      flagNxt = flag_r;
      ccNxt = cc_r;
      evReload = 1'b0;
      evInput = 1'b0;
      if (!enable) begin
         outNxt = polarity;
         ccNxt = timer_pkg::CC_WAIT;
      end else begin
         unique case (mode)
            timer_pkg::MODE_COMPARE: begin
               if (tick) begin
                  cntNxt = cnt_r + timer_pkg::COUNT_RESTART;
                  if (hit) begin
                     evReload = 1'b1;
                     outNxt = ~out_r;
                  end
               end
            end
            timer_pkg::MODE_GATED: begin
               if (tick && inAct) begin
                  if (hit) begin
                     cntNxt = timer_pkg::COUNT_RESTART;
                     evReload = 1'b1;
                     outNxt = ~out_r;
                     flagNxt = 1'b0;
                  end else begin
                     cntNxt = cnt_r + timer_pkg::COUNT_RESTART;
                  end
               end
               if (gateFall) begin
                  evInput = 1'b1;
                  flagNxt = 1'b1;
               end
            end
            timer_pkg::MODE_CAPCMP: begin
               unique case (cc_r)
                  timer_pkg::CC_WAIT: begin
                     if (qualEdge) begin
                        ccNxt = timer_pkg::CC_RUN;
                     end
                  end
                  timer_pkg::CC_RUN: begin
                     if (qualEdge) begin
                        capNxt = cnt_r;
                        cntNxt = timer_pkg::COUNT_RESTART;
                        evInput = 1'b1;
                        flagNxt = 1'b1;
                     end else if (tick) begin
                        if (hit) begin
                           cntNxt = timer_pkg::COUNT_RESTART;
                           evReload = 1'b1;
                           flagNxt = 1'b0;
                        end else begin
                           cntNxt = cnt_r + timer_pkg::COUNT_RESTART;
                        end
                     end
                  end
               endcase
            end
            default: begin
            end
         endcase
      end
      if (wrCount) begin
         cntNxt = wrHalf;
      end
      if (wrCapture) begin
         capNxt = lanes16(cap_r, wData_r, wStrb_r);
      end
   end

   // Interrupt selection; a new event beats a same-cycle clear
   logic inOk, reloadOk;
   assign inOk = (isel != timer_pkg::ISEL_RELOAD);
   assign reloadOk = (isel != timer_pkg::ISEL_INPUT);
   assign statNxt = (stat_r & ~statClr) | {evInput && inOk, evReload && reloadOk};

   // Timer state
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_r <= timer_pkg::COUNT_RST;
         cap_r <= timer_pkg::COUNT_RST;
         out_r <= 1'b0;
         flag_r <= 1'b0;
         cc_r <= timer_pkg::CC_WAIT;
         actPrev_r <= 1'b0;
         stat_r <= 2'h0;
      end else begin
         cnt_r <= cntNxt;
         cap_r <= capNxt;
         out_r <= outNxt;
         flag_r <= flagNxt;
         cc_r <= ccNxt;
         actPrev_r <= inAct;
         stat_r <= statNxt;
      end
   end

   // Software configuration
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reload_r <= timer_pkg::RELOAD_RST;
         ctrl0_r <= timer_pkg::CTRL_RST;
         ctrl1_r <= timer_pkg::CTRL_RST;
         mask_r <= 2'h0;
      end else begin
         if (wrReload) reload_r <= lanes16(reload_r, wData_r, wStrb_r);
         if (wrCtrl0) ctrl0_r <= wData_r[7:0];
         if (wrCtrl1) ctrl1_r <= wData_r[7:0];
         if (wrMask) mask_r <= wData_r[1:0];
      end
   end

   // Output routing
   assign timerOut = out_r;
   assign pinOut = out_r;
   assign pinOe = ctrl0_r[timer_pkg::C0_OUT_EN];
   assign irq = |(stat_r & mask_r);
   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   logic cmpRun, gateRun, ccRun;
   assign cmpRun = enable && (mode == timer_pkg::MODE_COMPARE) && !wrCount;
   assign gateRun = enable && (mode == timer_pkg::MODE_GATED) && !wrCount;
   assign ccRun = enable && (mode == timer_pkg::MODE_CAPCMP) && !wrCount && !wrCtrl1;

   a_compare_no_reset: assert property (cmpRun && tick && hit && !wrStatus
      |=> cnt_r == $past(cnt_r) + 16'h0001 && stat_r[timer_pkg::ST_RELOAD]
         == ($past(stat_r[timer_pkg::ST_RELOAD]) || $past(reloadOk)))
      else $error("Compare match did not keep counting");
   a_compare_toggle: assert property (cmpRun && tick && hit && !wrCtrl1
      |=> out_r != $past(out_r))
      else $error("Compare match did not invert output");
   a_wrap_zero: assert property (cmpRun && tick && cnt_r == timer_pkg::COUNT_ALL_ONES
      |=> cnt_r == 16'h0000)
      else $error("Count did not wrap to zero");
   a_gate_hold: assert property (gateRun && !inAct |=> $stable(cnt_r))
      else $error("Gated count moved while input idle");
   a_gate_deassert: assert property (gateRun && gateFall && !wrStatus && inOk
      |=> flag_r && stat_r[timer_pkg::ST_INPUT])
      else $error("Gate release did not flag input");
   a_gate_restart: assert property (gateRun && tick && inAct && hit && !wrCtrl1
      |=> cnt_r == 16'h0001 && out_r != $past(out_r))
      else $error("Gated reload did not restart at one");
   a_cap_idle: assert property (ccRun && cc_r == timer_pkg::CC_WAIT && !qualEdge
      |=> $stable(cnt_r))
      else $error("Count moved before first edge");
   a_cap_first_quiet: assert property (ccRun && cc_r == timer_pkg::CC_WAIT && qualEdge
      |=> (stat_r & ~$past(stat_r)) == 2'h0 ##1 cc_r == timer_pkg::CC_RUN || !enable)
      else $error("First edge raised an interrupt");
   a_cap_copy: assert property (ccRun && cc_r == timer_pkg::CC_RUN && qualEdge
      && !wrCapture |=> cap_r == $past(cnt_r) && cnt_r == 16'h0001 && flag_r)
      else $error("Capture edge did not copy count");
   a_cap_timeout: assert property (ccRun && cc_r == timer_pkg::CC_RUN
      && !qualEdge && tick && hit |=> cnt_r == 16'h0001 && !flag_r)
      else $error("Compare hit did not restart count");

   c_compare_match: cover property (cmpRun && tick && hit);
   c_gate_release: cover property (gateRun && gateFall);
   c_capture_edge: cover property (ccRun && cc_r == timer_pkg::CC_RUN && qualEdge);
   c_irq_rise: cover property ($rose(irq));
endmodule

//--- timer_input_model.sv
`timescale 1ns/1ps
module timer_input_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic sysRst,
   // Requested level and routing choice
   input wire logic level,
   input wire logic route,
   // Timer input lines
   output logic pinIn,
   output logic eventIn
);
   logic idle_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Unselected line flips every cycle so it never looks like a steady input
   always_ff @(posedge mclk) begin
      if (sysRst) begin
         idle_r <= 1'b0;
         pinIn <= 1'b0;
         eventIn <= 1'b0;
      end else begin
         idle_r <= ~idle_r;
         pinIn <= route ? idle_r : level;
         eventIn <= route ? level : idle_r;
      end
   end
endmodule

//--- timer_pkg.sv
package timer_pkg;
   // Register byte offsets on the AXI4-Lite port
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_COUNT = 8'h00;
   localparam logic [7:0] OFF_RELOAD = 8'h04;
   localparam logic [7:0] OFF_CAPTURE = 8'h08;
   localparam logic [7:0] OFF_CTRL0 = 8'h0c;
   localparam logic [7:0] OFF_CTRL1 = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_MASK = 8'h18;

   // Control register zero fields
   localparam int C0_OUT_EN = 0;
   localparam int C0_IN_SRC = 1;
   localparam int C0_EVT_FLAG = 3;
   localparam int C0_ISEL_LO = 4;
   localparam int C0_MODE_MSB = 7;

   // Control register one fields
   localparam int C1_MODE_LO = 0;
   localparam int C1_PRES_LO = 3;
   localparam int C1_POL = 6;
   localparam int C1_EN = 7;

   // Status and mask bit positions
   localparam int ST_RELOAD = 0;
   localparam int ST_INPUT = 1;

   // Mode codes and interrupt select codes
   localparam logic [3:0] MODE_COMPARE = 4'h5;
   localparam logic [3:0] MODE_GATED = 4'h6;
   localparam logic [3:0] MODE_CAPCMP = 4'h7;
   localparam logic [1:0] ISEL_INPUT = 2'h2;
   localparam logic [1:0] ISEL_RELOAD = 2'h3;

   // Reset and restart values
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] RELOAD_RST = 16'hffff;
   localparam logic [15:0] COUNT_RESTART = 16'h0001;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Capture/Compare wait and run states
   typedef enum logic {CC_WAIT, CC_RUN} cc_state_t;
endpackage
